// ===== rtl/gpc_params.svh
`ifndef GPC_PARAMS_SVH
`define GPC_PARAMS_SVH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define GPC_PORT_W      8
`define GPC_PORTS       4

// ----------------------------------------------------------------
// data-space offsets
// ----------------------------------------------------------------
`define GPC_PORT_BASE   8'h20
`define GPC_PORT_STRIDE 8'h03
`define GPC_OFS_INPUT   8'h00
`define GPC_OFS_DIR     8'h01
`define GPC_OFS_OUTPUT  8'h02
`define GPC_ADR_FLAGS   8'h3b
`define GPC_ADR_MCUCTL  8'h55
`define GPC_ADR_GRPEN   8'h68
`define GPC_ADR_MASK0   8'h6b
`define GPC_ADR_MASK1   8'h6c
`define GPC_ADR_MASK2   8'h6d
`define GPC_ADR_MASK3   8'h73

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define GPC_PUD_BIT     4
`define GPC_RST_BYTE    8'h00
`define GPC_RST_GRP     4'h0

`endif

// ===== rtl/gpc_pkg.sv
`include "gpc_params.svh"

package gpc_pkg;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef logic [`GPC_PORT_W-1:0] gpc_byte_type;
    typedef logic [`GPC_PORTS-1:0]  gpc_grp_type;

    typedef struct packed {
        gpc_byte_type dir;
        gpc_byte_type out;
        gpc_byte_type meta;
        gpc_byte_type pin;
        gpc_byte_type prev;
        gpc_byte_type change;
        gpc_byte_type pad_out;
        gpc_byte_type pad_oe;
        gpc_byte_type pad_pullup;
    } gpc_bank_state_type;

    typedef struct packed {
        gpc_byte_type [`GPC_PORTS-1:0] mask;
        gpc_grp_type                   grp_en;
        gpc_grp_type                   flag;
        gpc_grp_type                   irq_req;
        logic                          global_pullup_disable;
        gpc_byte_type                  rd_data;
    } gpc_top_state_type;

endpackage : gpc_pkg

// ===== rtl/gpc_port_bank.sv
`timescale 1ns/1ps
`include "gpc_params.svh"

module gpc_port_bank
    import gpc_pkg::*;
#(
    parameter int WIDTH = `GPC_PORT_W
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    // register writes
    input  wire logic             dir_wr_i,
    input  wire logic             out_wr_i,
    input  wire logic             toggle_wr_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    input  wire logic             pud_i,
    // alternate function overrides
    input  wire logic [WIDTH-1:0] alt_dir_en_i,
    input  wire logic [WIDTH-1:0] alt_dir_val_i,
    input  wire logic [WIDTH-1:0] alt_val_en_i,
    input  wire logic [WIDTH-1:0] alt_val_i,
    // pads
    input  wire logic [WIDTH-1:0] pad_in_i,
    output logic      [WIDTH-1:0] dir_o,
    output logic      [WIDTH-1:0] out_o,
    output logic      [WIDTH-1:0] pin_o,
    output logic      [WIDTH-1:0] change_o,
    output logic      [WIDTH-1:0] pad_out_o,
    output logic      [WIDTH-1:0] pad_oe_o,
    output logic      [WIDTH-1:0] pad_pullup_o
);

    // state is laid out for one byte-wide port only
    if (WIDTH != `GPC_PORT_W) begin : g_width_check
        $error("gpc_port_bank: WIDTH must equal the port width");
    end

    gpc_bank_state_type st;
    gpc_bank_state_type next_st;
    logic [WIDTH-1:0]   oe;

    always_comb begin
        next_st = st;
        oe      = '0;
        if (dir_wr_i) begin
            next_st.dir = wdata_i;
        end
        if (out_wr_i) begin
            next_st.out = wdata_i;
        end else if (toggle_wr_i) begin
            next_st.out = st.out ^ wdata_i;
        end
        // first stage feeds only the second; pin is read regardless of direction
        next_st.meta   = pad_in_i;
        next_st.pin    = st.meta;
        next_st.prev   = st.pin;
        next_st.change = st.pin ^ st.prev;
        // overrides act per pin, so the other pins keep plain behaviour
        for (int i = 0; i < WIDTH; i++) begin
            oe[i] = alt_dir_en_i[i] ? alt_dir_val_i[i] : next_st.dir[i];
            next_st.pad_oe[i]  = oe[i];
            next_st.pad_out[i] = alt_val_en_i[i] ? alt_val_i[i] : next_st.out[i];
            next_st.pad_pullup[i] = ~oe[i] & next_st.out[i] & ~pud_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dir_o        = st.dir;
    assign out_o        = st.out;
    assign pin_o        = st.pin;
    assign change_o     = st.change;
    assign pad_out_o    = st.pad_out;
    assign pad_oe_o     = st.pad_oe;
    assign pad_pullup_o = st.pad_pullup;

endmodule : gpc_port_bank

// ===== rtl/gpc_port_top.sv
`timescale 1ns/1ps
`include "gpc_params.svh"


module gpc_port_top
    import gpc_pkg::*;
#(
    parameter int PORTS  = `GPC_PORTS,
    parameter int PORT_W = `GPC_PORT_W
) (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    sys_rst_i,
    // data-space access
    input  wire logic [7:0]              addr_i,
    input  wire logic                    wr_en_i,
    input  wire logic [7:0]              wdata_i,
    input  wire logic                    rd_en_i,
    output logic      [7:0]              rd_data_o,
    // single-bit set and clear
    input  wire logic                    bit_set_i,
    input  wire logic                    bit_clr_i,
    input  wire logic [2:0]              bit_idx_i,
    // interrupt handshake with the core
    input  wire logic                    global_int_enable_i,
    input  wire logic [PORTS-1:0]        irq_ack_i,
    output logic      [PORTS-1:0]        irq_req_o,
    // alternate function overrides
    input  wire logic [PORTS*PORT_W-1:0] alt_dir_en_i,
    input  wire logic [PORTS*PORT_W-1:0] alt_dir_val_i,
    input  wire logic [PORTS*PORT_W-1:0] alt_val_en_i,
    input  wire logic [PORTS*PORT_W-1:0] alt_val_i,
    // pads
    input  wire logic [PORTS*PORT_W-1:0] pad_in_i,
    output logic      [PORTS*PORT_W-1:0] pad_out_o,
    output logic      [PORTS*PORT_W-1:0] pad_oe_o,
    output logic      [PORTS*PORT_W-1:0] pad_pullup_o
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (PORTS != `GPC_PORTS || PORT_W != `GPC_PORT_W) begin : g_size_check
        $error("gpc_port_top: only four byte-wide ports are mapped");
    end

    // ----------------------------------------------------------------
    // address helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] port_adr(input int p, input logic [7:0] ofs);
        port_adr = `GPC_PORT_BASE + 8'(p * `GPC_PORT_STRIDE) + ofs;
    endfunction : port_adr

    function automatic logic [7:0] mask_adr(input int g);
        case (g)
            0:       mask_adr = `GPC_ADR_MASK0;
            1:       mask_adr = `GPC_ADR_MASK1;
            2:       mask_adr = `GPC_ADR_MASK2;
            default: mask_adr = `GPC_ADR_MASK3;
        endcase
    endfunction : mask_adr

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    gpc_top_state_type         st;
    gpc_top_state_type         next_st;
    logic                      wr;
    logic [7:0]                cur;
    logic [7:0]                wd;
    logic [7:0]                one_hot;
    logic [PORTS-1:0]          dir_wr;
    logic [PORTS-1:0]          out_wr;
    logic [PORTS-1:0]          tog_wr;
    logic [PORTS-1:0]          evt;
    logic [PORTS-1:0]          clr;
    logic [PORTS*PORT_W-1:0]   dir_v;
    logic [PORTS*PORT_W-1:0]   out_v;
    logic [PORTS*PORT_W-1:0]   pin_v;
    logic [PORTS*PORT_W-1:0]   chg_v;
    logic [PORTS*PORT_W-1:0]   bank_oe;

    // ----------------------------------------------------------------
    // current value at the addressed location
    // ----------------------------------------------------------------
    always_comb begin
        cur = `GPC_RST_BYTE;
        for (int p = 0; p < PORTS; p++) begin
            if (addr_i == port_adr(p, `GPC_OFS_INPUT)) begin
                cur = pin_v[p*PORT_W +: PORT_W];
            end
            if (addr_i == port_adr(p, `GPC_OFS_DIR)) begin
                cur = dir_v[p*PORT_W +: PORT_W];
            end
            if (addr_i == port_adr(p, `GPC_OFS_OUTPUT)) begin
                cur = out_v[p*PORT_W +: PORT_W];
            end
            if (addr_i == mask_adr(p)) begin
                cur = st.mask[p];
            end
        end
        if (addr_i == `GPC_ADR_FLAGS) begin
            cur = {4'h0, st.flag};
        end
        if (addr_i == `GPC_ADR_GRPEN) begin
            cur = {4'h0, st.grp_en};
        end
        if (addr_i == `GPC_ADR_MCUCTL) begin
            cur = 8'h00;
            cur[`GPC_PUD_BIT] = st.global_pullup_disable;
        end
    end

    // ----------------------------------------------------------------
    // write data, single-bit operations folded in
    // ----------------------------------------------------------------
    // input and flag locations act on ones only, so a bit set there
    // writes the lone bit and a bit clear writes nothing
    always_comb begin
        one_hot = 8'h01 << bit_idx_i;
        wr      = wr_en_i | bit_set_i | bit_clr_i;
        wd      = wdata_i;
        if (bit_set_i) begin
            wd = cur | one_hot;
        end else if (bit_clr_i) begin
            wd = cur & ~one_hot;
        end
        for (int p = 0; p < PORTS; p++) begin
            if (addr_i == port_adr(p, `GPC_OFS_INPUT) && (bit_set_i || bit_clr_i)) begin
                wd = bit_set_i ? one_hot : 8'h00;
            end
        end
        if (addr_i == `GPC_ADR_FLAGS && (bit_set_i || bit_clr_i)) begin
            wd = bit_set_i ? one_hot : 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // port write strobes
    // ----------------------------------------------------------------
    always_comb begin
        for (int p = 0; p < PORTS; p++) begin
            dir_wr[p] = wr && (addr_i == port_adr(p, `GPC_OFS_DIR));
            out_wr[p] = wr && (addr_i == port_adr(p, `GPC_OFS_OUTPUT));
            tog_wr[p] = wr && (addr_i == port_adr(p, `GPC_OFS_INPUT));
        end
    end

    // ----------------------------------------------------------------
    // port banks
    // ----------------------------------------------------------------
    for (genvar p = 0; p < PORTS; p++) begin : g_bank
        gpc_port_bank #(
            .WIDTH        (PORT_W)
        ) u_bank (
            .clk_i        (clk_i),
            .sys_rst_i    (sys_rst_i),
            .dir_wr_i     (dir_wr[p]),
            .out_wr_i     (out_wr[p]),
            .toggle_wr_i  (tog_wr[p]),
            .wdata_i      (wd),
            // next value, so the pull-ups drop at the edge that sets the disable
            .pud_i        (next_st.global_pullup_disable),
            .alt_dir_en_i (alt_dir_en_i[p*PORT_W +: PORT_W]),
            .alt_dir_val_i(alt_dir_val_i[p*PORT_W +: PORT_W]),
            .alt_val_en_i (alt_val_en_i[p*PORT_W +: PORT_W]),
            .alt_val_i    (alt_val_i[p*PORT_W +: PORT_W]),
            .pad_in_i     (pad_in_i[p*PORT_W +: PORT_W]),
            .dir_o        (dir_v[p*PORT_W +: PORT_W]),
            .out_o        (out_v[p*PORT_W +: PORT_W]),
            .pin_o        (pin_v[p*PORT_W +: PORT_W]),
            .change_o     (chg_v[p*PORT_W +: PORT_W]),
            .pad_out_o    (pad_out_o[p*PORT_W +: PORT_W]),
            .pad_oe_o     (bank_oe[p*PORT_W +: PORT_W]),
            .pad_pullup_o (pad_pullup_o[p*PORT_W +: PORT_W])
        );
    end

    // ----------------------------------------------------------------
    // control registers, flags and requests
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        for (int g = 0; g < PORTS; g++) begin
            // a masked pin counts only while its group is enabled
            evt[g] = st.grp_en[g] & |(chg_v[g*PORT_W +: PORT_W] & st.mask[g]);
            clr[g] = irq_ack_i[g] | (wr && addr_i == `GPC_ADR_FLAGS && wd[g]);
            // a new change in the clearing cycle is kept
            next_st.flag[g] = evt[g] | (st.flag[g] & ~clr[g]);
            if (wr && addr_i == mask_adr(g)) begin
                next_st.mask[g] = wd;
            end
        end
        if (wr && addr_i == `GPC_ADR_GRPEN) begin
            next_st.grp_en = wd[3:0];
        end
        if (wr && addr_i == `GPC_ADR_MCUCTL) begin
            next_st.global_pullup_disable = wd[`GPC_PUD_BIT];
        end
        next_st.irq_req = next_st.flag & next_st.grp_en
                          & {PORTS{global_int_enable_i}};
        if (rd_en_i) begin
            next_st.rd_data = cur;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st.mask    <= '0;
            st.grp_en  <= `GPC_RST_GRP;
            st.flag    <= `GPC_RST_GRP;
            st.irq_req <= `GPC_RST_GRP;
            st.global_pullup_disable     <= 1'b0;
            st.rd_data <= `GPC_RST_BYTE;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign rd_data_o = st.rd_data;
    assign irq_req_o = st.irq_req;
    // reset must float the pins without waiting for a clock edge,
    // so the registered enable is gated by the reset level itself
    assign pad_oe_o  = bank_oe & ~{(PORTS*PORT_W){sys_rst_i}};

endmodule : gpc_port_top

// ===== test/gpc_pin_model.sv
`timescale 1ns/1ps

module gpc_pin_model #(
    parameter int W = 32
) (
    // clock
    input  wire logic         clk_i,
    // device pads
    input  wire logic [W-1:0] pad_out_i,
    input  wire logic [W-1:0] pad_oe_i,
    input  wire logic [W-1:0] pad_pullup_i,
    // board drivers
    input  wire logic [W-1:0] drv_en_i,
    input  wire logic [W-1:0] drv_val_i,
    output logic      [W-1:0] level_o
);
    logic [W-1:0] last = '0;

    // a floating pin flips each cycle so no settled value is mistaken for a real one
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (pad_oe_i[i]) begin
                level_o[i] = pad_out_i[i];
            end else if (drv_en_i[i]) begin
                level_o[i] = drv_val_i[i];
            end else if (pad_pullup_i[i]) begin
                level_o[i] = 1'b1;
            end else begin
                level_o[i] = ~last[i];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        last <= level_o;
    end
endmodule : gpc_pin_model

// ===== test/gpc_port_checker.sv
`timescale 1ns/1ps
`include "gpc_params.svh"

module gpc_port_checker
    import gpc_pkg::*;
#(
    parameter int PORTS  = 4,
    parameter int PORT_W = 8
) (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    sys_rst_i,
    // register access
    input  wire logic [7:0]              addr_i,
    input  wire logic                    wr_en_i,
    input  wire logic [7:0]              wdata_i,
    input  wire logic                    rd_en_i,
    input  wire logic [7:0]              rd_data_o,
    input  wire logic                    bit_set_i,
    input  wire logic [2:0]              bit_idx_i,
    // interrupts
    input  wire logic                    global_int_enable_i,
    input  wire logic [PORTS-1:0]        irq_req_o,
    // overrides and pads
    input  wire logic [PORTS*PORT_W-1:0] alt_dir_en_i,
    input  wire logic [PORTS*PORT_W-1:0] alt_val_en_i,
    input  wire logic [PORTS*PORT_W-1:0] pad_out_o,
    input  wire logic [PORTS*PORT_W-1:0] pad_oe_o,
    input  wire logic [PORTS*PORT_W-1:0] pad_pullup_o
);
    default clocking cb @(posedge clk_i); endclocking

    // port 0 write with no override on its pins
    sequence s_wr0(a);
        wr_en_i && addr_i == a && alt_val_en_i[7:0] == 8'h00 && alt_dir_en_i[7:0] == 8'h00;
    endsequence

    property p_rst_oe;
        sys_rst_i |-> pad_oe_o == '0;
    endproperty
    property p_rst_clear;
        sys_rst_i |=> pad_out_o == '0 && pad_pullup_o == '0 && irq_req_o == '0 && rd_data_o == 8'h00;
    endproperty
    property p_pull_excl;
        disable iff (sys_rst_i) (pad_pullup_o & pad_oe_o) == '0;
    endproperty
    property p_irq_gie;
        disable iff (sys_rst_i) (|irq_req_o) |-> $past(global_int_enable_i);
    endproperty
    property p_dir_wr;
        disable iff (sys_rst_i) s_wr0(8'h21) |=> pad_oe_o[7:0] == $past(wdata_i);
    endproperty
    property p_out_wr;
        disable iff (sys_rst_i) s_wr0(8'h22) |=> pad_out_o[7:0] == $past(wdata_i);
    endproperty
    property p_toggle;
        disable iff (sys_rst_i) s_wr0(8'h20) |=> pad_out_o[7:0] == ($past(pad_out_o[7:0]) ^ $past(wdata_i));
    endproperty
    property p_bit_set;
        disable iff (sys_rst_i) bit_set_i && addr_i == 8'h21 && alt_dir_en_i[7:0] == 8'h00
            && $past(alt_dir_en_i[7:0]) == 8'h00
            |=> pad_oe_o[7:0] == ($past(pad_oe_o[7:0]) | (8'h01 << $past(bit_idx_i)));
    endproperty
    property p_pud;
        disable iff (sys_rst_i) wr_en_i && addr_i == 8'h55 && wdata_i[4] |=> pad_pullup_o == '0;
    endproperty
    property p_flag_read;
        disable iff (sys_rst_i) rd_en_i && addr_i == 8'h3b |=> rd_data_o[7:4] == 4'h0;
    endproperty

    a_rst_oe: assert property (p_rst_oe) else $error("pads driven in reset");
    a_rst_clear: assert property (p_rst_clear) else $error("outputs not cleared by reset");
    a_pull_excl: assert property (p_pull_excl) else $error("pull-up on a driven pin");
    a_irq_gie: assert property (p_irq_gie) else $error("vector request without global enable");
    a_dir_wr: assert property (p_dir_wr) else $error("enable differs from direction");
    a_out_wr: assert property (p_out_wr) else $error("drive differs from output");
    a_toggle: assert property (p_toggle) else $error("input write did not toggle");
    a_bit_set: assert property (p_bit_set) else $error("bit set touched other bits");
    a_pud: assert property (p_pud) else $error("pull-up left on under disable");
    a_flag_read: assert property (p_flag_read) else $error("upper flag bits not zero");
endmodule : gpc_port_checker

// ===== test/gpio_port_pin_change_mask_bench.sv
`timescale 1ns/1ps
`include "gpc_params.svh"

module gpio_port_pin_change_mask_bench import gpc_pkg::*;;
    logic        clk_i = 1'b0, sys_rst_i = 1'b1, wr_en_i = 1'b0, rd_en_i = 1'b0, gie = 1'b0;
    logic        bit_set_i = 1'b0, bit_clr_i = 1'b0;
    logic [7:0]  addr_i = 8'h00, wdata_i = 8'h00, rd_data_o;
    logic [2:0]  bit_idx_i = 3'h0;
    logic [3:0]  irq_ack_i = 4'h0, irq_req_o;
    logic [31:0] alt_dir_en_i = '0, pad_in_i, pad_out_o, pad_oe_o, pad_pullup_o;
    logic [31:0] drv_en = '1, drv_val = '0, seed = 32'ha4f81249;
    logic [7:0]  regs [0:7] = '{8'h6b, 8'h6c, 8'h6d, 8'h73, 8'h68, 8'h3b, 8'h21, 8'h00};
    int          mismatches = 0, samples_checked = 0;

    gpc_port_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wr_en_i(wr_en_i),
        .wdata_i(wdata_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .bit_set_i(bit_set_i),
        .bit_clr_i(bit_clr_i), .bit_idx_i(bit_idx_i), .global_int_enable_i(gie), .irq_ack_i(irq_ack_i),
        .irq_req_o(irq_req_o), .alt_dir_en_i(alt_dir_en_i), .alt_dir_val_i('0), .alt_val_en_i('0),
        .alt_val_i('0), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
        .pad_pullup_o(pad_pullup_o));
    gpc_pin_model #(.W(32)) u_pins (.clk_i(clk_i), .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
        .pad_pullup_i(pad_pullup_o), .drv_en_i(drv_en), .drv_val_i(drv_val), .level_o(pad_in_i));

    initial begin
        forever #20 clk_i = ~clk_i;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] rnd8();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd8

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            mismatches++;
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_i = a;
        wdata_i = d;
        wr_en_i = 1'b1;
        @(negedge clk_i);
        wr_en_i = 1'b0;
    endtask : wr

    task automatic bitop(input logic s, input logic [7:0] a, input logic [2:0] i);
        @(negedge clk_i);
        addr_i = a;
        bit_idx_i = i;
        bit_set_i = s;
        bit_clr_i = ~s;
        @(negedge clk_i);
        bit_set_i = 1'b0;
        bit_clr_i = 1'b0;
    endtask : bitop

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] care);
        @(negedge clk_i);
        addr_i = a;
        rd_en_i = 1'b1;
        @(negedge clk_i);
        rd_en_i = 1'b0;
        @(negedge clk_i);
        chk("rd_data_o", exp & care, rd_data_o & care);
    endtask : rd

    task automatic tally_and_finish();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] o, d, e, n, t, v;
        logic [2:0] b;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        sys_rst_i = 1'b0;
        foreach (regs[i]) rd(regs[i], 8'h00, 8'hff);
        for (int g = 0; g < 4; g++) begin
            v = rnd8();
            wr(regs[g], v);
            rd(regs[g], v, 8'hff);
        end
        // output first, then direction, so no forbidden jump is made
        for (int p = 0; p < 4; p++) begin
            o = rnd8();
            d = rnd8();
            e = rnd8();
            n = rnd8();
            drv_val[8*p +: 8] = e;
            drv_en[8*p +: 8] = n;
            wr(8'(8'h22 + 3 * p), o);
            wr(8'(8'h21 + 3 * p), d);
            chk("pad_oe_o", d, pad_oe_o[8*p +: 8]);
            chk("pad_out_o", o, pad_out_o[8*p +: 8]);
            chk("pad_pullup_o", ~d & o, pad_pullup_o[8*p +: 8]);
            // the pin level needs two edges through the synchroniser
            @(negedge clk_i);
            rd(8'(8'h20 + 3 * p), (d & o) | (~d & n & e) | (~d & ~n & o), d | n | o);
        end
        wr(8'h55, 8'h10);
        chk("pad_pullup_o", 8'h00, {7'h0, |pad_pullup_o});
        wr(8'h55, 8'h00);
        chk("pad_pullup_o", ~d & o, pad_pullup_o[31:24]);
        drv_en = '1;
        o = rnd8();
        t = rnd8();
        wr(8'h22, o);
        wr(8'h20, t);
        rd(8'h22, o ^ t, 8'hff);
        // port 0 direction known again; only direction bits move, never both bits of a pin
        d = rnd8();
        wr(8'h21, d);
        for (int k = 0; k < 8; k++) begin
            v = rnd8();
            bitop(v[3], 8'h21, v[2:0]);
            d = v[3] ? (d | (8'h01 << v[2:0])) : (d & ~(8'h01 << v[2:0]));
            chk("pad_oe_o", d, pad_oe_o[7:0]);
        end
        rd(8'h21, d, 8'hff);
        bitop(1'b1, 8'h20, 3'd5);
        chk("pad_out_o", o ^ t ^ 8'h20, pad_out_o[7:0]);
        @(negedge clk_i);
        alt_dir_en_i = 32'h1;
        @(negedge clk_i);
        chk("pad_oe_o", d & 8'hfe, pad_oe_o[7:0]);
        alt_dir_en_i = '0;
        // pin-change groups: clear everything first so stale flags do not leak in
        for (int g = 0; g < 4; g++) begin
            wr(regs[g], 8'h00);
            wr(8'(8'h21 + 3 * g), 8'h00);
        end
        wr(8'h68, 8'h00);
        repeat (4) @(negedge clk_i);
        wr(8'h3b, 8'h0f);
        rd(8'h3b, 8'h00, 8'hff);
        for (int g = 0; g < 4; g++) begin
            v = rnd8();
            b = v[2:0];
            wr(regs[g], 8'h01 << b);
            wr(8'h68, 8'(1 << g));
            gie = 1'b1;
            drv_val[8*g + b] = ~drv_val[8*g + b];
            for (int w = 0; w < 8 && irq_req_o[g] !== 1'b1; w++) @(negedge clk_i);
            chk("irq_req_o", 8'h01, {7'h0, irq_req_o[g]});
            if (irq_req_o[g] !== 1'b1) tally_and_finish();
            rd(8'h3b, 8'(1 << g), 8'hff);
            irq_ack_i[g] = 1'b1;
            @(negedge clk_i);
            irq_ack_i = 4'h0;
            chk("irq_req_o", 8'h00, {7'h0, irq_req_o[g]});
            drv_val[8*g + 3'(b + 3'd1)] = ~drv_val[8*g + 3'(b + 3'd1)];
            repeat (6) @(negedge clk_i);
            chk("irq_req_o", 8'h00, {7'h0, irq_req_o[g]});
            gie = 1'b0;
            drv_val[8*g + b] = ~drv_val[8*g + b];
            repeat (6) @(negedge clk_i);
            chk("irq_req_o", 8'h00, {7'h0, irq_req_o[g]});
            rd(8'h3b, 8'(1 << g), 8'hff);
            wr(8'h3b, 8'(1 << g));
            rd(8'h3b, 8'h00, 8'hff);
        end
        wr(8'h21, 8'hff);
        sys_rst_i = 1'b1;
        #1;
        chk("pad_oe_o", 8'h00, {7'h0, |pad_oe_o});
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        sys_rst_i = 1'b0;
        rd(8'h21, 8'h00, 8'hff);
        tally_and_finish();
    end
endmodule : gpio_port_pin_change_mask_bench

bind gpc_port_top gpc_port_checker #(.PORTS(PORTS), .PORT_W(PORT_W)) u_chk (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wr_en_i(wr_en_i), .wdata_i(wdata_i), .rd_en_i(rd_en_i),
    .rd_data_o(rd_data_o), .bit_set_i(bit_set_i), .bit_idx_i(bit_idx_i),
    .global_int_enable_i(global_int_enable_i), .irq_req_o(irq_req_o), .alt_dir_en_i(alt_dir_en_i),
    .alt_val_en_i(alt_val_en_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .pad_pullup_o(pad_pullup_o));
